//--- core/port_b_pkg.sv
package port_b_pkg;

  // ------------------------------------------------------------
  // Register indexes on the register port
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_ANALOG_SEL = 4'h0;
  localparam logic [3:0] ADDR_INT_MAIN   = 4'h1;
  localparam logic [3:0] ADDR_INT_EDGE   = 4'h2;
  localparam logic [3:0] ADDR_INT_EXT    = 4'h3;
  localparam logic [3:0] ADDR_CHANGE_EN  = 4'h4;
  localparam logic [3:0] ADDR_LATCH      = 4'h5;
  localparam logic [3:0] ADDR_PIN_DATA   = 4'h6;
  localparam logic [3:0] ADDR_SLEW       = 4'h7;
  localparam logic [3:0] ADDR_DIRECTION  = 4'h8;
  localparam logic [3:0] ADDR_PULLUP     = 4'h9;
  localparam logic [3:0] ADDR_RELOC_FUSE = 4'ha;
  localparam logic [3:0] ADDR_DEBUG_FUSE = 4'hb;
  localparam logic [3:0] ADDR_EVT_STATUS = 4'hc;
  localparam logic [3:0] ADDR_EVT_MASK   = 4'hd;

  // ------------------------------------------------------------
  // Implemented bit masks
  // ------------------------------------------------------------
  localparam logic [7:0] MASK_ANALOG_SEL = 8'h3f;
  localparam logic [7:0] MASK_INT_EDGE   = 8'hf5;
  localparam logic [7:0] MASK_INT_EXT    = 8'hdb;
  localparam logic [7:0] MASK_CHANGE_EN  = 8'hf0;
  localparam logic [7:0] MASK_SLEW       = 8'h1f;
  localparam logic [7:0] MASK_RELOC_FUSE = 8'hbf;
  localparam logic [7:0] MASK_DEBUG_FUSE = 8'hc5;
  localparam logic [7:0] MASK_EVT        = 8'h03;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_EVEN       = 6;
  localparam int BIT_ODD        = 7;
  localparam int BIT_CHG_FLAG   = 0;
  localparam int BIT_CHG_ENABLE = 3;
  localparam int BIT_LVP        = 2;
  localparam int BIT_CAP2_MX    = 0;
  localparam int BIT_CAP3_MX    = 2;
  localparam int BIT_T3CK_MX    = 4;
  localparam int BIT_PWM2B_MX   = 5;
  localparam int EVT_CHANGE     = 0;
  localparam int EVT_DEBUG      = 1;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_ANALOG_SEL = 8'h3f;
  localparam logic [7:0] RST_DIRECTION  = 8'hff;
  localparam logic [7:0] RST_RELOC_FUSE = 8'hbf;
  localparam logic [7:0] RST_DEBUG_FUSE = 8'h85;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic sync_mode;
    logic clock_master;
    logic transmit_out;
    logic sync_clock_out;
    logic sync_data_out;
    logic sync_data_drive;
  } serial_ctrl_t;

  typedef struct packed {
    logic active;
    logic data_out;
    logic data_drive;
  } debug_ctrl_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

endpackage : port_b_pkg

//--- core/port_b_upper_pins_mux.sv
`timescale 1ns/1ps
// Functional notes
// (RULE1) Direction 0: pin driven from latch bit, analog selection ignored.
// (RULE2) Direction 1: data read returns pin; analog select blanks digital input. Code masks analog bits 7:6 to zero, so it never blanks.
// (RULE3) Both upper pins are change-interrupt inputs when set as inputs.
// (RULE4) Small variant: even pin carries async transmit, overriding direction.
// (RULE5) Sync mode: even pin is clock, output as master, input as slave.
// (RULE6) Small variant: odd pin carries async receive input.
// (RULE7) Sync mode: odd pin is data, output transmitting, input receiving.
// (RULE8) Debug: even pin is program clock in, odd pin program data.
// (RULE9) Unimplemented register bits read back as zero.
// (RULE10) Relocatable functions use default pins when fuse set, else alternate.
// (RULE11) Low-voltage program bit changes only in high-voltage program mode.
// (RULE12) Enabled change pin differing from last read sets change flag.
module port_b_upper_pins_mux
  import port_b_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // Register port
  input  wire logic [3:0]   addr_i,
  input  wire logic [7:0]   wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic      [7:0]   rdata_o,
  // Pins
  input  wire logic         upper_even_pin_i,
  output logic              upper_even_pin_o,
  output logic              upper_even_pin_oe_o,
  input  wire logic         upper_odd_pin_i,
  output logic              upper_odd_pin_o,
  output logic              upper_odd_pin_oe_o,
  // Peripheral and debug side
  input  wire serial_ctrl_t serial_i,
  input  wire debug_ctrl_t  debug_i,
  input  wire logic         hv_program_i,
  output logic              serial_receive_in_o,
  output logic              serial_sync_clock_o,
  output logic              serial_sync_data_o,
  output logic              program_clock_in_o,
  output logic              program_data_in_o,
  output logic [3:0]        relocate_default_o,
  // Interrupt
  output logic              irq_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
    masked = v & m;
  endfunction : masked

  function automatic logic wr_hit(input logic we, input logic [3:0] a,
                                  input logic [3:0] target);
    wr_hit = we && (a == target);
  endfunction : wr_hit

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] analog_select_reg_r;
  logic [7:0] int_main_r;
  logic [7:0] int_edge_r;
  logic [7:0] int_ext_r;
  logic [7:0] change_enable_reg_r;
  logic [7:0] output_latch_r;
  logic [7:0] slew_control_reg_r;
  logic [7:0] direction_reg_r;
  logic [7:0] pullup_enable_reg_r;
  logic [7:0] relocation_fuse_reg_r;
  logic [7:0] debug_fuse_reg_r;
  logic [7:0] evt_status_r;
  logic [7:0] evt_mask_r;
  logic [1:0] last_read_r;
  logic       debug_seen_r;
  logic [7:0] rdata_nxt;
  logic [7:0] int_main_nxt;
  logic [7:0] evt_status_nxt;
  logic [7:0] debug_fuse_nxt;

  // ------------------------------------------------------------
  // Pin levels and digital input path
  // ------------------------------------------------------------
  wire [1:0] pin_level  = {upper_odd_pin_i, upper_even_pin_i};
  wire [1:0] dir_upper  = direction_reg_r[BIT_ODD:BIT_EVEN];
  wire [7:0] ana_all    = masked(analog_select_reg_r, MASK_ANALOG_SEL);
  wire [1:0] ana_upper  = ana_all[BIT_ODD:BIT_EVEN];
  // (RULE2) ana_upper is always 0 under MASK_ANALOG_SEL, input never blanked
  wire [1:0] dig_in     = pin_level & ~ana_upper;
  wire [1:0] pin_read   = (dig_in & dir_upper)
                          | (output_latch_r[BIT_ODD:BIT_EVEN] & ~dir_upper);
  wire [7:0] pin_data_rd = {pin_read, 6'h00};

  // ------------------------------------------------------------
  // Change detection
  // ------------------------------------------------------------
  wire [1:0] chg_en     = change_enable_reg_r[BIT_ODD:BIT_EVEN];
  // (RULE3) inputs only
  wire [1:0] chg_armed  = chg_en & dir_upper;
  // (RULE12) mismatch sets flag
  wire       chg_event  = |(chg_armed & (dig_in ^ last_read_r));
  wire       rd_pin     = rd_i && (addr_i == ADDR_PIN_DATA);

  // ------------------------------------------------------------
  // Pin function selection
  // ------------------------------------------------------------
  wire dbg      = debug_i.active;
  wire async_on = serial_i.enable && !serial_i.sync_mode && SMALL_VARIANT;
  wire sync_on  = serial_i.enable && serial_i.sync_mode;
  pin_drive_t even_nxt;
  pin_drive_t odd_nxt;

  // (RULE8) debug owns both pins
  // (RULE4) async transmit
  // (RULE5) sync clock
  // (RULE1) latch drive
  assign even_nxt = dbg      ? pin_drive_t'{out: 1'b0, oe: 1'b0} :
                    async_on ? pin_drive_t'{out: serial_i.transmit_out, oe: 1'b1} :
                    sync_on  ? pin_drive_t'{out: serial_i.sync_clock_out,
                                            oe: serial_i.clock_master} :
                               pin_drive_t'{out: output_latch_r[BIT_EVEN],
                                            oe: ~direction_reg_r[BIT_EVEN]};

  // (RULE8) program data
  // (RULE6) async receive
  // (RULE7) sync data
  // (RULE1) latch drive
  assign odd_nxt  = dbg      ? pin_drive_t'{out: debug_i.data_out, oe: debug_i.data_drive} :
                    async_on ? pin_drive_t'{out: 1'b0, oe: 1'b0} :
                    sync_on  ? pin_drive_t'{out: serial_i.sync_data_out,
                                            oe: serial_i.sync_data_drive} :
                               pin_drive_t'{out: output_latch_r[BIT_ODD],
                                            oe: ~direction_reg_r[BIT_ODD]};

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  wire wr_int_main = wr_hit(wr_i, addr_i, ADDR_INT_MAIN);
  wire wr_debug    = wr_hit(wr_i, addr_i, ADDR_DEBUG_FUSE);
  wire wr_status   = wr_hit(wr_i, addr_i, ADDR_EVT_STATUS);
  wire dbg_rise    = dbg && !debug_seen_r;

  // Set wins over software clear
  always_comb begin
    int_main_nxt = wr_int_main ? wdata_i : int_main_r;
    if (chg_event) begin
      int_main_nxt[BIT_CHG_FLAG] = 1'b1;
    end
  end

  always_comb begin
    evt_status_nxt = evt_status_r;
    if (wr_status) begin
      evt_status_nxt = evt_status_r & ~wdata_i;
    end
    evt_status_nxt[EVT_CHANGE] = evt_status_nxt[EVT_CHANGE] | chg_event;
    evt_status_nxt[EVT_DEBUG]  = evt_status_nxt[EVT_DEBUG] | dbg_rise;
  end

  // (RULE11) LOW_VOLTAGE_PROGRAM_ENABLE locked outside HV
  always_comb begin
    debug_fuse_nxt = debug_fuse_reg_r;
    if (wr_debug) begin
      debug_fuse_nxt = masked(wdata_i, MASK_DEBUG_FUSE);
      if (!hv_program_i) begin
        debug_fuse_nxt[BIT_LVP] = debug_fuse_reg_r[BIT_LVP];
      end
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  // (RULE9) unimplemented reads zero
  always_comb begin
    case (addr_i)
      ADDR_ANALOG_SEL: rdata_nxt = masked(analog_select_reg_r, MASK_ANALOG_SEL);
      ADDR_INT_MAIN:   rdata_nxt = int_main_r;
      ADDR_INT_EDGE:   rdata_nxt = masked(int_edge_r, MASK_INT_EDGE);
      ADDR_INT_EXT:    rdata_nxt = masked(int_ext_r, MASK_INT_EXT);
      ADDR_CHANGE_EN:  rdata_nxt = masked(change_enable_reg_r, MASK_CHANGE_EN);
      ADDR_LATCH:      rdata_nxt = output_latch_r;
      ADDR_PIN_DATA:   rdata_nxt = pin_data_rd;
      ADDR_SLEW:       rdata_nxt = masked(slew_control_reg_r, MASK_SLEW);
      ADDR_DIRECTION:  rdata_nxt = direction_reg_r;
      ADDR_PULLUP:     rdata_nxt = pullup_enable_reg_r;
      ADDR_RELOC_FUSE: rdata_nxt = masked(relocation_fuse_reg_r, MASK_RELOC_FUSE);
      ADDR_DEBUG_FUSE: rdata_nxt = debug_fuse_reg_r;
      ADDR_EVT_STATUS: rdata_nxt = evt_status_r;
      ADDR_EVT_MASK:   rdata_nxt = evt_mask_r;
      default:         rdata_nxt = RST_ZERO;
    endcase
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      analog_select_reg_r   <= RST_ANALOG_SEL;
      int_edge_r            <= RST_ZERO;
      int_ext_r             <= RST_ZERO;
      change_enable_reg_r   <= RST_ZERO;
      output_latch_r        <= RST_ZERO;
      slew_control_reg_r    <= RST_ZERO;
      direction_reg_r       <= RST_DIRECTION;
      pullup_enable_reg_r   <= RST_ZERO;
      relocation_fuse_reg_r <= RST_RELOC_FUSE;
      evt_mask_r            <= RST_ZERO;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_ANALOG_SEL: analog_select_reg_r   <= masked(wdata_i, MASK_ANALOG_SEL);
        ADDR_INT_EDGE:   int_edge_r            <= masked(wdata_i, MASK_INT_EDGE);
        ADDR_INT_EXT:    int_ext_r             <= masked(wdata_i, MASK_INT_EXT);
        ADDR_CHANGE_EN:  change_enable_reg_r   <= masked(wdata_i, MASK_CHANGE_EN);
        ADDR_LATCH:      output_latch_r        <= wdata_i;
        ADDR_PIN_DATA:   output_latch_r        <= wdata_i;
        ADDR_SLEW:       slew_control_reg_r    <= masked(wdata_i, MASK_SLEW);
        ADDR_DIRECTION:  direction_reg_r       <= wdata_i;
        ADDR_PULLUP:     pullup_enable_reg_r   <= wdata_i;
        ADDR_RELOC_FUSE: relocation_fuse_reg_r <= masked(wdata_i, MASK_RELOC_FUSE);
        ADDR_EVT_MASK:   evt_mask_r            <= masked(wdata_i, MASK_EVT);
        default:         evt_mask_r            <= evt_mask_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Status, flags and read data
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_main_r       <= RST_ZERO;
      evt_status_r     <= RST_ZERO;
      debug_fuse_reg_r <= RST_DEBUG_FUSE;
      last_read_r      <= 2'h0;
      debug_seen_r     <= 1'b0;
      rdata_o          <= RST_ZERO;
      irq_o            <= 1'b0;
    end else begin
      int_main_r       <= int_main_nxt;
      evt_status_r     <= evt_status_nxt;
      debug_fuse_reg_r <= debug_fuse_nxt;
      last_read_r      <= rd_pin ? dig_in : last_read_r;
      debug_seen_r     <= dbg;
      rdata_o          <= rd_i ? rdata_nxt : RST_ZERO;
      irq_o            <= |(evt_status_nxt & evt_mask_r)
                          | (int_main_nxt[BIT_CHG_FLAG]
                             & int_main_r[BIT_CHG_ENABLE]);
    end
  end

  // ------------------------------------------------------------
  // Pin drive and peripheral inputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upper_even_pin_o    <= 1'b0;
      upper_even_pin_oe_o <= 1'b0;
      upper_odd_pin_o     <= 1'b0;
      upper_odd_pin_oe_o  <= 1'b0;
      serial_receive_in_o <= 1'b1;
      serial_sync_clock_o <= 1'b0;
      serial_sync_data_o  <= 1'b0;
      program_clock_in_o  <= 1'b0;
      program_data_in_o   <= 1'b0;
      relocate_default_o  <= 4'hf;
    end else begin
      upper_even_pin_o    <= even_nxt.out;
      upper_even_pin_oe_o <= even_nxt.oe;
      upper_odd_pin_o     <= odd_nxt.out;
      upper_odd_pin_oe_o  <= odd_nxt.oe;
      serial_receive_in_o <= async_on ? upper_odd_pin_i : 1'b1;
      serial_sync_clock_o <= sync_on ? upper_even_pin_i : 1'b0;
      serial_sync_data_o  <= sync_on ? upper_odd_pin_i : 1'b0;
      program_clock_in_o  <= dbg ? upper_even_pin_i : 1'b0;
      program_data_in_o   <= dbg ? upper_odd_pin_i : 1'b0;
      // (RULE10) fuse set selects default
      relocate_default_o  <= {relocation_fuse_reg_r[BIT_PWM2B_MX],
                              relocation_fuse_reg_r[BIT_T3CK_MX],
                              relocation_fuse_reg_r[BIT_CAP3_MX],
                              relocation_fuse_reg_r[BIT_CAP2_MX]};
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_plain_gpio;
    !dbg && !serial_i.enable;
  endsequence

  sequence s_debug_on;
    dbg;
  endsequence

  a_latch_drive_even: assert property ( // RULE1
    @(posedge clk_i) disable iff (!rstn_i)
    s_plain_gpio ##0 !direction_reg_r[BIT_EVEN] |=>
      upper_even_pin_oe_o && upper_even_pin_o == $past(output_latch_r[BIT_EVEN]))
    else $error("even pin not driven from latch");

  a_pin_read_value: assert property ( // RULE2
    @(posedge clk_i) disable iff (!rstn_i)
    rd_pin && direction_reg_r[BIT_ODD] |=>
      rdata_o[BIT_ODD] == $past(upper_odd_pin_i && !ana_upper[1]))
    else $error("pin read does not show pin level");

  a_change_input_only: assert property ( // RULE3
    @(posedge clk_i) disable iff (!rstn_i)
    (dir_upper == 2'h0) && !wr_int_main && !int_main_r[BIT_CHG_FLAG] |=>
      !int_main_r[BIT_CHG_FLAG])
    else $error("change flag set from output pin");

  a_async_tx_drive: assert property ( // RULE4
    @(posedge clk_i) disable iff (!rstn_i)
    !dbg && async_on |=>
      upper_even_pin_oe_o && upper_even_pin_o == $past(serial_i.transmit_out))
    else $error("transmit not on even pin");

  a_sync_clock_dir: assert property ( // RULE5
    @(posedge clk_i) disable iff (!rstn_i)
    !dbg && sync_on |=> upper_even_pin_oe_o == $past(serial_i.clock_master))
    else $error("sync clock direction wrong");

  a_async_rx_input: assert property ( // RULE6
    @(posedge clk_i) disable iff (!rstn_i)
    !dbg && async_on |=>
      !upper_odd_pin_oe_o && serial_receive_in_o == $past(upper_odd_pin_i))
    else $error("receive path wrong on odd pin");

  a_sync_data_dir: assert property ( // RULE7
    @(posedge clk_i) disable iff (!rstn_i)
    !dbg && sync_on |=> upper_odd_pin_oe_o == $past(serial_i.sync_data_drive))
    else $error("sync data direction wrong");

  a_debug_owns_pins: assert property ( // RULE8
    @(posedge clk_i) disable iff (!rstn_i)
    s_debug_on ##1 s_debug_on |->
      !upper_even_pin_oe_o && upper_odd_pin_oe_o == $past(debug_i.data_drive)
      && program_clock_in_o == $past(upper_even_pin_i))
    else $error("debug does not own pins");

  a_unimpl_zero: assert property ( // RULE9
    @(posedge clk_i) disable iff (!rstn_i)
    rd_i && addr_i == ADDR_CHANGE_EN |=> rdata_o[3:0] == 4'h0)
    else $error("unimplemented bits read nonzero");

  a_relocate_follow: assert property ( // RULE10
    @(posedge clk_i) disable iff (!rstn_i)
    relocate_default_o[0] == $past(relocation_fuse_reg_r[BIT_CAP2_MX]))
    else $error("relocation select wrong");

  a_lvp_locked: assert property ( // RULE11
    @(posedge clk_i) disable iff (!rstn_i)
    wr_debug && !hv_program_i |=> $stable(debug_fuse_reg_r[BIT_LVP]))
    else $error("low voltage bit changed outside hv mode");

  a_change_sets_flag: assert property ( // RULE12
    @(posedge clk_i) disable iff (!rstn_i)
    chg_event |=> int_main_r[BIT_CHG_FLAG] && evt_status_r[EVT_CHANGE])
    else $error("change did not set flag");

endmodule : port_b_upper_pins_mux

//--- verification/port_b_upper_pins_mux_tb.sv
`timescale 1ns/1ps
module port_b_upper_pins_mux_tb
  import port_b_pkg::*;
;
  logic         clk, rstn, wr, rd, rd_d, hv, ext_e, ext_o, ext_en;
  logic [3:0]   addr, reloc;
  logic [7:0]   wdata, rdata, d, v;
  logic         even_i, even_o, even_oe, odd_i, odd_o, odd_oe;
  logic         rx_in, sck, sdt, pclk, pdat, irq;
  serial_ctrl_t serial;
  debug_ctrl_t  debug;
  logic [7:0]   exp_q[$];
  int           bad_count, comparisons, cycles;

  port_b_upper_pins_mux #(.SMALL_VARIANT(1'b1)) dut (
    .clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .upper_even_pin_i(even_i), .upper_even_pin_o(even_o),
    .upper_even_pin_oe_o(even_oe), .upper_odd_pin_i(odd_i), .upper_odd_pin_o(odd_o),
    .upper_odd_pin_oe_o(odd_oe), .serial_i(serial), .debug_i(debug), .hv_program_i(hv),
    .serial_receive_in_o(rx_in), .serial_sync_clock_o(sck), .serial_sync_data_o(sdt),
    .program_clock_in_o(pclk), .program_data_in_o(pdat), .relocate_default_o(reloc),
    .irq_o(irq));
  port_pin_partner even_far (.clk_i(clk), .dev_out_i(even_o), .dev_oe_i(even_oe),
    .ext_val_i(ext_e), .ext_en_i(ext_en), .pin_o(even_i));
  port_pin_partner odd_far (.clk_i(clk), .dev_out_i(odd_o), .dev_oe_i(odd_oe),
    .ext_val_i(ext_o), .ext_en_i(ext_en), .pin_o(odd_i));

  // ------------------------------------------------------------
  // Clock, watchdog and read monitor
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    rd_d <= rd;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      check(rdata, exp_q.pop_front());
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] dt);
    @(posedge clk);
    addr <= a;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clk);
    rd <= 1'b0;
  endtask : reg_rd

  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic finish_test();
    $display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [3:0] maddr[5];
    logic [7:0] mval[5];
    maddr = '{ADDR_ANALOG_SEL, ADDR_INT_EDGE, ADDR_INT_EXT, ADDR_CHANGE_EN, ADDR_SLEW};
    mval = '{MASK_ANALOG_SEL, MASK_INT_EDGE, MASK_INT_EXT, MASK_CHANGE_EN, MASK_SLEW};
    {rstn, wr, rd, rd_d, hv, ext_e, ext_o} = '0;
    ext_en = 1'b1;
    {addr, wdata, serial, debug} = '0;
    {bad_count, comparisons, cycles} = '0;
    void'($urandom(63));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    reg_rd(ADDR_ANALOG_SEL, 8'h3f);
    reg_rd(ADDR_DIRECTION, 8'hff);
    reg_rd(ADDR_RELOC_FUSE, 8'hbf);
    reg_rd(ADDR_DEBUG_FUSE, 8'h85);
    for (int i = 0; i < 5; i++) begin
      reg_wr(maddr[i], 8'hff);
      reg_rd(maddr[i], mval[i]);
    end
    reg_wr(4'he, 8'hff);
    reg_rd(4'he, 8'h00);
    reg_wr(ADDR_CHANGE_EN, 8'h00);
    // Plain output from latch
    d = 8'($urandom);
    reg_wr(ADDR_DIRECTION, 8'h3f);
    reg_wr(ADDR_LATCH, d);
    reg_rd(ADDR_LATCH, d);
    settle();
    check(8'({even_o, even_oe, odd_o, odd_oe}), 8'({d[6], 1'b1, d[7], 1'b1}));
    // Input read and change interrupt
    reg_wr(ADDR_DIRECTION, 8'hff);
    reg_wr(ADDR_CHANGE_EN, 8'hc0);
    reg_wr(ADDR_INT_MAIN, 8'h08);
    reg_rd(ADDR_PIN_DATA, 8'h00);
    settle();
    check(8'(irq), 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      if (i == 0) ext_e <= 1'b1;
      else ext_o <= 1'b1;
      settle();
      check(8'(irq), 8'h01);
      reg_rd(ADDR_INT_MAIN, 8'h09);
      reg_rd(ADDR_EVT_STATUS, 8'h01);
      reg_rd(ADDR_PIN_DATA, (i == 0) ? 8'h40 : 8'hc0);
      reg_wr(ADDR_INT_MAIN, 8'h08);
      reg_wr(ADDR_EVT_STATUS, 8'h01);
      settle();
      check(8'(irq), 8'h00);
    end
    reg_wr(ADDR_CHANGE_EN, 8'h00);
    // Serial async, sync and debug overrides
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      serial <= {1'b1, 1'b0, 1'b0, k[0], 3'b000};
      ext_o <= k[1];
      settle();
      check(8'({even_o, even_oe, odd_oe, rx_in}), 8'({k[0], 1'b1, 1'b0, k[1]}));
      v = 8'($urandom);
      @(posedge clk);
      serial <= {1'b1, 1'b1, k[0], 1'b0, v[0], v[1], k[1]};
      ext_e <= v[2];
      ext_o <= v[3];
      settle();
      check(8'({even_oe, sck}), 8'({k[0], k[0] ? v[0] : v[2]}));
      check(8'({odd_oe, sdt}), 8'({k[1], k[1] ? v[1] : v[3]}));
    end
    @(posedge clk);
    serial <= '0;
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      @(posedge clk);
      debug <= {1'b1, v[0], k[0]};
      ext_e <= v[1];
      ext_o <= v[2];
      settle();
      check(8'({even_oe, pclk}), 8'({1'b0, v[1]}));
      check(8'({odd_oe, pdat}), 8'({k[0], k[0] ? v[0] : v[2]}));
    end
    check(8'(irq), 8'h00);
    reg_wr(ADDR_EVT_MASK, 8'h02);
    settle();
    check(8'(irq), 8'h01);
    reg_wr(ADDR_EVT_STATUS, 8'h02);
    settle();
    check(8'(irq), 8'h00);
    @(posedge clk);
    debug <= '0;
    // Relocation fuses and protected program bit
    d = 8'($urandom);
    reg_wr(ADDR_RELOC_FUSE, d);
    reg_rd(ADDR_RELOC_FUSE, d & MASK_RELOC_FUSE);
    settle();
    check(8'(reloc), 8'({d[5], d[4], d[2], d[0]}));
    reg_wr(ADDR_DEBUG_FUSE, 8'h00);
    reg_rd(ADDR_DEBUG_FUSE, 8'h04);
    hv <= 1'b1;
    reg_wr(ADDR_DEBUG_FUSE, 8'h00);
    reg_rd(ADDR_DEBUG_FUSE, 8'h00);
    settle();
    finish_test();
  end
endmodule : port_b_upper_pins_mux_tb

//--- verification/port_pin_partner.sv
`timescale 1ns/1ps
module port_pin_partner (
  // Clock
  input  wire logic clk_i,
  // Device side of the pin
  input  wire logic dev_out_i,
  input  wire logic dev_oe_i,
  // Far-side driver or programmer
  input  wire logic ext_val_i,
  input  wire logic ext_en_i,
  // Resolved pin level
  output logic      pin_o
);
  logic float_r = 1'b0;

  // Undriven pin wanders
  always_ff @(posedge clk_i) begin
    float_r <= ~float_r;
  end

  assign pin_o = dev_oe_i ? dev_out_i : (ext_en_i ? ext_val_i : float_r);
endmodule : port_pin_partner
